//--- shared/pin_ctrl_pkg.sv
// Contract
// [R1] The low pin register is 24 bits with six 4-bit codes, pin 0 in 3..0 up to pin 5 in 23..20.
// [R2] The high pin register is 24 bits with pin 6 in 3..0 up to pin 11 in 23..20.
// [R3] Codes 0000 to 0100 select debounced input, raw input, output, open-collector output and serial port.
// [R4] Codes 1000 to 1100 select those same five functions with the pin signal inverted.
// [R5] Code 1111 routes the pin to an auxiliary converter input.
// [R6] Software does not write codes 0101, 0110, 0111, 1101 or 1110, which have no defined behaviour.
// [R7] Filter field bits 9..8 select 4-bit hysteresis for 00 and 5-bit hysteresis for 01 on a 12-bit level.
// [R8] Filter value 10 bypasses filter and hysteresis, and 11 bypasses only the low-pass filter.
// [R9] The power control register holds bit 7 main converters, bit 6 reference buffer, bit 5 reference, bits 3..0 output converters, reset zero.
// [R10] Bit 15 of the auxiliary enable register turns the auxiliary converter on, reset zero.
// [R11] Bit 2 of the oscillator register powers the oscillator down, reset zero.
// [R12] Software writes 01 to setup bits 1..0 to initialise the output converters; other values are reserved.
// [R13] The top bit of each pin code inverts the signal into or out of the pin; the code inverts only for codes 1000 to 1100, not for 1111.
// [R14] An enabled auxiliary converter filters by default unless the filter field selects a bypass.
// [R15] Every register reads back what was written, with reserved bits reading zero.
package pin_ctrl_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 24;
   localparam int unsigned NUM_PINS = 12;
   localparam int unsigned PINS_PER_REG = 6;
   localparam int unsigned CODE_W = 4;
   localparam int unsigned NUM_AUX = 4;

   // Register offsets
   localparam logic [15:0] PIN_FUNCTION_LOW_OFS = 16'h0820;
   localparam logic [15:0] PIN_FUNCTION_HIGH_OFS = 16'h0821;
   localparam logic [15:0] AUX_FILTER_POWER_CONTROL_OFS = 16'h0822;
   localparam logic [15:0] AUX_CONVERTER_ENABLE_OFS = 16'h0824;
   localparam logic [15:0] OSCILLATOR_POWER_DOWN_OFS = 16'h0826;
   localparam logic [15:0] OUTPUT_CONVERTER_SETUP_OFS = 16'h0827;

   // Reset values
   localparam logic [23:0] PIN_FUNCTION_RST = 24'h000000;
   localparam logic [15:0] CTRL16_RST = 16'h0000;

   // Writable bit masks, reserved bits read zero
   localparam logic [15:0] AUX_FILTER_POWER_MASK = 16'h03ef;
   localparam logic [15:0] AUX_CONVERTER_ENABLE_MASK = 16'h8000;
   localparam logic [15:0] OSCILLATOR_POWER_DOWN_MASK = 16'h0004;
   localparam logic [15:0] OUTPUT_CONVERTER_SETUP_MASK = 16'h0003;

   // Field positions
   localparam int unsigned FILTER_LSB = 8;
   localparam int unsigned MAIN_CONV_PD_BIT = 7;
   localparam int unsigned REF_BUF_PD_BIT = 6;
   localparam int unsigned REF_PD_BIT = 5;
   localparam int unsigned AUX_ON_BIT = 15;
   localparam int unsigned OSC_PD_BIT = 2;
   localparam int unsigned INVERT_BIT = 3;

   // Pin function codes, inversion bit cleared except in the auxiliary input code
   localparam logic [2:0] FN_IN_DEBOUNCED = 3'h0;
   localparam logic [2:0] FN_IN_RAW = 3'h1;
   localparam logic [2:0] FN_OUT = 3'h2;
   localparam logic [2:0] FN_OPEN_COLLECTOR = 3'h3;
   localparam logic [2:0] FN_SERIAL_PORT = 3'h4;
   localparam logic [3:0] FN_AUX_INPUT = 4'hf;

   // Auxiliary filter selections
   localparam logic [1:0] FILT_HYST4 = 2'h0;
   localparam logic [1:0] FILT_HYST5 = 2'h1;
   localparam logic [1:0] FILT_BYPASS_ALL = 2'h2;
   localparam logic [1:0] FILT_BYPASS_LPF = 2'h3;

   // Converter setup code that initialises the output converters
   localparam logic [1:0] SETUP_INIT = 2'h1;

   // Pin that feeds each auxiliary channel 0..3
   localparam int unsigned AUX_PIN_CH0 = 9;
   localparam int unsigned AUX_PIN_CH1 = 2;
   localparam int unsigned AUX_PIN_CH2 = 3;
   localparam int unsigned AUX_PIN_CH3 = 8;

   typedef enum logic [2:0] {
      REG_NONE = 3'h0,
      REG_PIN_LOW = 3'h1,
      REG_PIN_HIGH = 3'h2,
      REG_FILT_PWR = 3'h3,
      REG_AUX_EN = 3'h4,
      REG_OSC = 3'h5,
      REG_SETUP = 3'h6
   } reg_sel_t;
endpackage

//--- hw/pin_code_decode.sv
// Turns one pin function code into one-hot function selects
module pin_code_decode (
   input wire logic [3:0] pin_function_code,
   output logic in_debounced,
   output logic in_raw,
   output logic drive_out,
   output logic open_collector,
   output logic serial_port,
   output logic aux_input,
   output logic invert,
   output logic code_reserved
);
   logic [2:0] base;

   // Low three bits pick the digital function
   always_comb begin
      base = pin_function_code[2:0];
      in_debounced = 1'b0;
      in_raw = 1'b0;
      drive_out = 1'b0;
      open_collector = 1'b0;
      serial_port = 1'b0;
      aux_input = 1'b0;
      invert = 1'b0;
      code_reserved = 1'b0;
      if (pin_function_code == pin_ctrl_pkg::FN_AUX_INPUT) begin
         aux_input = 1'b1; // R5
      end else begin
         invert = pin_function_code[pin_ctrl_pkg::INVERT_BIT]; // R4 R13
         case (base)
            pin_ctrl_pkg::FN_IN_DEBOUNCED: in_debounced = 1'b1; // R3
            pin_ctrl_pkg::FN_IN_RAW: in_raw = 1'b1; // R3
            pin_ctrl_pkg::FN_OUT: drive_out = 1'b1; // R3
            pin_ctrl_pkg::FN_OPEN_COLLECTOR: open_collector = 1'b1; // R3
            pin_ctrl_pkg::FN_SERIAL_PORT: serial_port = 1'b1; // R3
            default: begin
               // Unassigned codes select nothing and leave the pin idle
               invert = 1'b0;
               code_reserved = 1'b1; // R6
            end
         endcase
      end
   end
endmodule

//--- hw/pin_function_power_ctrl_regs.sv
// Register bank for pin functions, auxiliary converter and power control
module pin_function_power_ctrl_regs (
   input wire logic clk,
   input wire logic sys_rst,
   // Control port register access
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [23:0] reg_wdata,
   input wire logic reg_rd,
   output logic [23:0] reg_rdata,
   output logic reg_rvalid,
   output logic reg_addr_err,
   // Per-pin function selects
   output logic [11:0] pin_in_debounced,
   output logic [11:0] pin_in_raw,
   output logic [11:0] pin_drive_out,
   output logic [11:0] pin_open_collector,
   output logic [11:0] pin_serial_port,
   output logic [11:0] pin_aux_input,
   output logic [11:0] pin_invert,
   output logic [11:0] pin_pullup_en,
   output logic [11:0] pin_code_reserved,
   // Auxiliary converter control
   output logic aux_converter_on,
   output logic [3:0] aux_channel_active,
   output logic aux_lowpass_active,
   output logic aux_hysteresis_active,
   output logic aux_hysteresis_wide,
   output logic [1:0] aux_filter_select,
   // Power control
   output logic main_converters_power_down,
   output logic reference_buffer_power_down,
   output logic reference_power_down,
   output logic out_conv0_power_down,
   output logic out_conv1_power_down,
   output logic out_conv2_power_down,
   output logic out_conv3_power_down,
   output logic osc_power_down,
   output logic [1:0] converter_setup_code,
   output logic converter_init_ok
);
   // Maps an address to the register it selects
   function automatic pin_ctrl_pkg::reg_sel_t reg_select(
      input logic [15:0] addr
   );
      pin_ctrl_pkg::reg_sel_t sel;
      sel = pin_ctrl_pkg::REG_NONE;
      case (addr)
         pin_ctrl_pkg::PIN_FUNCTION_LOW_OFS: sel = pin_ctrl_pkg::REG_PIN_LOW;
         pin_ctrl_pkg::PIN_FUNCTION_HIGH_OFS:
            sel = pin_ctrl_pkg::REG_PIN_HIGH;
         pin_ctrl_pkg::AUX_FILTER_POWER_CONTROL_OFS:
            sel = pin_ctrl_pkg::REG_FILT_PWR;
         pin_ctrl_pkg::AUX_CONVERTER_ENABLE_OFS:
            sel = pin_ctrl_pkg::REG_AUX_EN;
         pin_ctrl_pkg::OSCILLATOR_POWER_DOWN_OFS:
            sel = pin_ctrl_pkg::REG_OSC;
         pin_ctrl_pkg::OUTPUT_CONVERTER_SETUP_OFS:
            sel = pin_ctrl_pkg::REG_SETUP;
         default: sel = pin_ctrl_pkg::REG_NONE;
      endcase
      return sel;
   endfunction

   // Picks the four-bit code of one pin out of both pin registers
   function automatic logic [3:0] pin_code(
      input logic [23:0] low,
      input logic [23:0] high,
      input int unsigned pin
   );
      logic [47:0] both;
      both = {high, low};
      return both[pin * 4 +: 4];
   endfunction

   pin_ctrl_pkg::reg_sel_t sel;

   // Stored configuration
   logic [23:0] pin_low_q, pin_low_d;
   logic [23:0] pin_high_q, pin_high_d;
   logic [15:0] filt_pwr_q, filt_pwr_d;
   logic [15:0] aux_en_q, aux_en_d;
   logic [15:0] osc_q, osc_d;
   logic [15:0] setup_q, setup_d;

   // Read side
   logic [23:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic addr_err_q, addr_err_d;

   assign sel = reg_select(reg_addr);

   // Write path, reserved bits masked off so they read zero
   always_comb begin
      pin_low_d = pin_low_q;
      pin_high_d = pin_high_q;
      filt_pwr_d = filt_pwr_q;
      aux_en_d = aux_en_q;
      osc_d = osc_q;
      setup_d = setup_q;
      if (reg_wr) begin
         case (sel)
            pin_ctrl_pkg::REG_PIN_LOW: pin_low_d = reg_wdata; // R1
            pin_ctrl_pkg::REG_PIN_HIGH: pin_high_d = reg_wdata; // R2
            pin_ctrl_pkg::REG_FILT_PWR:
               filt_pwr_d = reg_wdata[15:0] &
                  pin_ctrl_pkg::AUX_FILTER_POWER_MASK; // R9 R15
            pin_ctrl_pkg::REG_AUX_EN:
               aux_en_d = reg_wdata[15:0] &
                  pin_ctrl_pkg::AUX_CONVERTER_ENABLE_MASK; // R10 R15
            pin_ctrl_pkg::REG_OSC:
               osc_d = reg_wdata[15:0] &
                  pin_ctrl_pkg::OSCILLATOR_POWER_DOWN_MASK; // R11 R15
            pin_ctrl_pkg::REG_SETUP:
               setup_d = reg_wdata[15:0] &
                  pin_ctrl_pkg::OUTPUT_CONVERTER_SETUP_MASK; // R15
            default: begin
               // Unmapped writes change nothing
               pin_low_d = pin_low_q;
            end
         endcase
      end
   end

   // Configuration registers, all zero after reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_low_q <= pin_ctrl_pkg::PIN_FUNCTION_RST;
         pin_high_q <= pin_ctrl_pkg::PIN_FUNCTION_RST;
         filt_pwr_q <= pin_ctrl_pkg::CTRL16_RST; // R9
         aux_en_q <= pin_ctrl_pkg::CTRL16_RST; // R10
         osc_q <= pin_ctrl_pkg::CTRL16_RST; // R11
         setup_q <= pin_ctrl_pkg::CTRL16_RST;
      end else begin
         pin_low_q <= pin_low_d;
         pin_high_q <= pin_high_d;
         filt_pwr_q <= filt_pwr_d;
         aux_en_q <= aux_en_d;
         osc_q <= osc_d;
         setup_q <= setup_d;
      end
   end

   // Read mux, narrow registers sit in the low bits
   always_comb begin
      rdata_d = rdata_q;
      rvalid_d = 1'b0;
      addr_err_d = 1'b0;
      if (reg_rd) begin
         rvalid_d = 1'b1;
         case (sel)
            pin_ctrl_pkg::REG_PIN_LOW: rdata_d = pin_low_q; // R15
            pin_ctrl_pkg::REG_PIN_HIGH: rdata_d = pin_high_q; // R15
            pin_ctrl_pkg::REG_FILT_PWR: rdata_d = {8'h00, filt_pwr_q};
            pin_ctrl_pkg::REG_AUX_EN: rdata_d = {8'h00, aux_en_q};
            pin_ctrl_pkg::REG_OSC: rdata_d = {8'h00, osc_q};
            pin_ctrl_pkg::REG_SETUP: rdata_d = {8'h00, setup_q};
            default: begin
               rdata_d = 24'h000000;
               addr_err_d = 1'b1;
            end
         endcase
      end else if (reg_wr && sel == pin_ctrl_pkg::REG_NONE) begin
         addr_err_d = 1'b1;
      end
   end

   // Read answer registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= 24'h000000;
         rvalid_q <= 1'b0;
         addr_err_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         addr_err_q <= addr_err_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign reg_addr_err = addr_err_q;

   // Per-pin decode of the stored codes
   logic [11:0] dec_in_deb, dec_in_raw, dec_out, dec_oc;
   logic [11:0] dec_sp, dec_aux, dec_inv, dec_rsv;

   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++) begin : g_pin
         pin_code_decode u_dec (
            .pin_function_code(pin_code(pin_low_q, pin_high_q, gi)), // R1 R2
            .in_debounced(dec_in_deb[gi]),
            .in_raw(dec_in_raw[gi]),
            .drive_out(dec_out[gi]),
            .open_collector(dec_oc[gi]),
            .serial_port(dec_sp[gi]),
            .aux_input(dec_aux[gi]),
            .invert(dec_inv[gi]),
            .code_reserved(dec_rsv[gi])
         );
      end
   endgenerate

   // Registered function selects
   logic [11:0] fn_in_deb_q, fn_in_deb_d;
   logic [11:0] fn_in_raw_q, fn_in_raw_d;
   logic [11:0] fn_out_q, fn_out_d;
   logic [11:0] fn_oc_q, fn_oc_d;
   logic [11:0] fn_sp_q, fn_sp_d;
   logic [11:0] fn_aux_q, fn_aux_d;
   logic [11:0] fn_inv_q, fn_inv_d;
   logic [11:0] fn_pull_q, fn_pull_d;
   logic [11:0] fn_rsv_q, fn_rsv_d;

   // Pull-up on digital inputs, serial port pins counted as inputs
   always_comb begin
      fn_in_deb_d = dec_in_deb; // R3
      fn_in_raw_d = dec_in_raw; // R3
      fn_out_d = dec_out; // R3
      fn_oc_d = dec_oc; // R3
      fn_sp_d = dec_sp; // R3
      fn_aux_d = dec_aux; // R5
      fn_inv_d = dec_inv; // R4 R13
      fn_pull_d = dec_in_deb | dec_in_raw | dec_sp;
      fn_rsv_d = dec_rsv; // R6
   end

   // Function select registers follow the pin codes one cycle later
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fn_in_deb_q <= 12'h000;
         fn_in_raw_q <= 12'h000;
         fn_out_q <= 12'h000;
         fn_oc_q <= 12'h000;
         fn_sp_q <= 12'h000;
         fn_aux_q <= 12'h000;
         fn_inv_q <= 12'h000;
         fn_pull_q <= 12'h000;
         fn_rsv_q <= 12'h000;
      end else begin
         fn_in_deb_q <= fn_in_deb_d;
         fn_in_raw_q <= fn_in_raw_d;
         fn_out_q <= fn_out_d;
         fn_oc_q <= fn_oc_d;
         fn_sp_q <= fn_sp_d;
         fn_aux_q <= fn_aux_d;
         fn_inv_q <= fn_inv_d;
         fn_pull_q <= fn_pull_d;
         fn_rsv_q <= fn_rsv_d;
      end
   end

   assign pin_in_debounced = fn_in_deb_q;
   assign pin_in_raw = fn_in_raw_q;
   assign pin_drive_out = fn_out_q;
   assign pin_open_collector = fn_oc_q;
   assign pin_serial_port = fn_sp_q;
   assign pin_aux_input = fn_aux_q;
   assign pin_invert = fn_inv_q;
   assign pin_pullup_en = fn_pull_q;
   assign pin_code_reserved = fn_rsv_q;

   // Auxiliary converter state derived from the stored fields
   logic [1:0] filt_sel;
   logic aux_on;
   logic [3:0] chan_q, chan_d;
   logic lpf_q, lpf_d;
   logic hyst_q, hyst_d;
   logic wide_q, wide_d;

   assign filt_sel = filt_pwr_q[pin_ctrl_pkg::FILTER_LSB +: 2]; // R7
   assign aux_on = aux_en_q[pin_ctrl_pkg::AUX_ON_BIT]; // R10

   // Filter and hysteresis only run while the converter is on
   always_comb begin
      chan_d[0] = aux_on && fn_aux_q[pin_ctrl_pkg::AUX_PIN_CH0];
      chan_d[1] = aux_on && fn_aux_q[pin_ctrl_pkg::AUX_PIN_CH1];
      chan_d[2] = aux_on && fn_aux_q[pin_ctrl_pkg::AUX_PIN_CH2];
      chan_d[3] = aux_on && fn_aux_q[pin_ctrl_pkg::AUX_PIN_CH3];
      lpf_d = 1'b0;
      hyst_d = 1'b0;
      wide_d = 1'b0;
      if (aux_on) begin
         case (filt_sel)
            pin_ctrl_pkg::FILT_HYST4: begin
               lpf_d = 1'b1; // R14
               hyst_d = 1'b1; // R7
            end
            pin_ctrl_pkg::FILT_HYST5: begin
               lpf_d = 1'b1; // R14
               hyst_d = 1'b1; // R7
               wide_d = 1'b1; // R7
            end
            pin_ctrl_pkg::FILT_BYPASS_ALL: begin
               lpf_d = 1'b0; // R8
               hyst_d = 1'b0; // R8
            end
            pin_ctrl_pkg::FILT_BYPASS_LPF: begin
               lpf_d = 1'b0; // R8
               hyst_d = 1'b1; // R8
            end
            default: begin
               lpf_d = 1'b1;
               hyst_d = 1'b1;
            end
         endcase
      end
   end

   // Auxiliary converter control registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         chan_q <= 4'h0;
         lpf_q <= 1'b0;
         hyst_q <= 1'b0;
         wide_q <= 1'b0;
      end else begin
         chan_q <= chan_d;
         lpf_q <= lpf_d;
         hyst_q <= hyst_d;
         wide_q <= wide_d;
      end
   end

   assign aux_converter_on = aux_on;
   assign aux_channel_active = chan_q;
   assign aux_lowpass_active = lpf_q;
   assign aux_hysteresis_active = hyst_q;
   assign aux_hysteresis_wide = wide_q;
   assign aux_filter_select = filt_sel;

   // Power-down controls straight from the stored bits
   assign main_converters_power_down =
      filt_pwr_q[pin_ctrl_pkg::MAIN_CONV_PD_BIT]; // R9
   assign reference_buffer_power_down =
      filt_pwr_q[pin_ctrl_pkg::REF_BUF_PD_BIT]; // R9
   assign reference_power_down = filt_pwr_q[pin_ctrl_pkg::REF_PD_BIT]; // R9
   assign out_conv0_power_down = filt_pwr_q[3]; // R9
   assign out_conv1_power_down = filt_pwr_q[2]; // R9
   assign out_conv2_power_down = filt_pwr_q[1]; // R9
   assign out_conv3_power_down = filt_pwr_q[0]; // R9
   assign osc_power_down = osc_q[pin_ctrl_pkg::OSC_PD_BIT]; // R11

   // Output converters count as set up only for the initialise code
   assign converter_setup_code = setup_q[1:0];
   assign converter_init_ok =
      setup_q[1:0] == pin_ctrl_pkg::SETUP_INIT; // R12
endmodule

//--- bench/pin_ctrl_sva.sv
// Port-level checks for the pin function and power control bank
module pin_ctrl_sva (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [23:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic reg_rvalid,
   input wire logic reg_addr_err,
   input wire logic [11:0] pin_aux_input,
   input wire logic [11:0] pin_drive_out,
   input wire logic aux_converter_on,
   input wire logic [3:0] aux_channel_active,
   input wire logic aux_lowpass_active,
   input wire logic aux_hysteresis_active,
   input wire logic aux_hysteresis_wide,
   input wire logic [1:0] aux_filter_select,
   input wire logic main_converters_power_down,
   input wire logic osc_power_down,
   input wire logic [1:0] converter_setup_code,
   input wire logic converter_init_ok
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Address decode of the six mapped registers
   logic mapped;
   assign mapped = reg_addr inside {16'h0820, 16'h0821, 16'h0822,
      16'h0824, 16'h0826, 16'h0827};

   // Steps of a low pin register update
   sequence s_low_wr;
      reg_wr && reg_addr == 16'h0820;
   endsequence
   sequence s_low_idle;
      !(reg_wr && reg_addr == 16'h0820);
   endsequence

   a_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered after one cycle");
   a_unmapped_flag: assert property (
      (reg_rd || reg_wr) && !mapped |=> reg_addr_err)
      else $error("unmapped access not flagged");
   a_aux_enable_bit: assert property (
      reg_wr && reg_addr == 16'h0824 |=>
      aux_converter_on == $past(reg_wdata[15]))
      else $error("aux enable bit wrong");
   a_filter_power: assert property (
      reg_wr && reg_addr == 16'h0822 |=>
      {aux_filter_select, main_converters_power_down} ==
      $past(reg_wdata[9:7]))
      else $error("filter or power bits wrong");
   a_osc_down_bit: assert property (
      reg_wr && reg_addr == 16'h0826 |=>
      osc_power_down == $past(reg_wdata[2]))
      else $error("oscillator power bit wrong");
   a_init_decode: assert property (
      converter_init_ok == (converter_setup_code == 2'h1))
      else $error("init flag wrong");
   a_lowpass_flag: assert property (
      aux_lowpass_active ==
      $past(aux_converter_on && !aux_filter_select[1]))
      else $error("lowpass flag wrong");
   a_hyst_flags: assert property (
      {aux_hysteresis_active, aux_hysteresis_wide} ==
      $past({aux_converter_on && aux_filter_select != 2'h2,
      aux_converter_on && aux_filter_select == 2'h1}))
      else $error("hysteresis flags wrong");
   a_aux_channel_map: assert property (
      aux_channel_active == $past({4{aux_converter_on}} &
      {pin_aux_input[8], pin_aux_input[3], pin_aux_input[2],
      pin_aux_input[9]}))
      else $error("aux channel map wrong");
   a_pin_low_decode: assert property (
      s_low_wr ##1 s_low_idle |=>
      pin_aux_input[0] == ($past(reg_wdata[3:0], 2) == 4'hf) &&
      pin_drive_out[5] == ($past(reg_wdata[23:20], 2) inside
      {4'h2, 4'ha}))
      else $error("pin code decode wrong");
endmodule

bind pin_function_power_ctrl_regs pin_ctrl_sva pin_ctrl_sva_inst (
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
   .reg_rvalid(reg_rvalid), .reg_addr_err(reg_addr_err),
   .pin_aux_input(pin_aux_input), .pin_drive_out(pin_drive_out),
   .aux_converter_on(aux_converter_on),
   .aux_channel_active(aux_channel_active),
   .aux_lowpass_active(aux_lowpass_active),
   .aux_hysteresis_active(aux_hysteresis_active),
   .aux_hysteresis_wide(aux_hysteresis_wide),
   .aux_filter_select(aux_filter_select),
   .main_converters_power_down(main_converters_power_down),
   .osc_power_down(osc_power_down),
   .converter_setup_code(converter_setup_code),
   .converter_init_ok(converter_init_ok));

//--- bench/pin_function_power_ctrl_regs_tb_top.sv
// Compare two values and count the outcome
`define CHK(g, e) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      err_total++; \
      $display("wrong value at %0t: got %h exp %h", $time, g, e); \
   end \
end

module pin_function_power_ctrl_regs_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, sys_rst, reg_wr, reg_rd, reg_rvalid, reg_addr_err;
   logic [15:0] reg_addr;
   logic [23:0] reg_wdata, reg_rdata, d, lo, hi;
   logic aux_converter_on, aux_lowpass_active, aux_hysteresis_active;
   logic aux_hysteresis_wide, main_converters_power_down, osc_power_down;
   logic reference_buffer_power_down, reference_power_down;
   logic out_conv0_power_down, out_conv1_power_down, out_conv2_power_down;
   logic out_conv3_power_down, converter_init_ok;
   logic [1:0] aux_filter_select, converter_setup_code;
   logic [3:0] aux_channel_active;
   logic [11:0] pin_in_debounced, pin_in_raw, pin_drive_out, pin_invert;
   logic [11:0] pin_open_collector, pin_serial_port, pin_aux_input;
   logic [11:0] pin_pullup_en, pin_code_reserved;
   logic [24:0] e, exp_q[$];
   logic [3:0] cd[12];
   logic [15:0] addrs[7] = '{16'h0820, 16'h0821, 16'h0822, 16'h0824,
      16'h0826, 16'h0827, 16'h0823};
   logic [23:0] masks[7] = '{24'hffffff, 24'hffffff, 24'h0003ef,
      24'h008000, 24'h000004, 24'h000003, 24'h000000};
   logic [3:0] legal[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9,
      4'ha, 4'hb, 4'hc, 4'hf};
   int err_total = 0;
   int checks_done = 0;
   int seed = 32'hdf4b2b1e;

   pin_function_power_ctrl_regs pin_function_power_ctrl_regs_inst (
      .clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
      .reg_rvalid, .reg_addr_err, .pin_in_debounced, .pin_in_raw,
      .pin_drive_out, .pin_open_collector, .pin_serial_port, .pin_aux_input,
      .pin_invert, .pin_pullup_en, .pin_code_reserved, .aux_converter_on,
      .aux_channel_active, .aux_lowpass_active, .aux_hysteresis_active,
      .aux_hysteresis_wide, .aux_filter_select, .main_converters_power_down,
      .reference_buffer_power_down, .reference_power_down,
      .out_conv0_power_down, .out_conv1_power_down, .out_conv2_power_down,
      .out_conv3_power_down, .osc_power_down, .converter_setup_code,
      .converter_init_ok);

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Verdict and end of run
   task automatic complete_run;
      if (err_total == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // One write strobe cycle
   task automatic wr(input logic [15:0] a, input logic [23:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // One read strobe cycle, expected flag and data noted
   task automatic rd(input logic [15:0] a, input logic [24:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask

   // Let decoded outputs land, then sample off the edge
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Read answers against the oldest note
   always @(posedge clk) begin
      if (reg_rvalid === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : {25{1'bx}};
         `CHK({reg_addr_err, reg_rdata}, e)
      end
   end

   // Hang guard
   initial begin
      #200000;
      err_total++;
      complete_run();
   end

   // Main sequence
   initial begin
      logic [2:0] b;
      logic v;
      logic [8:0] pg, pe;
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 24'h000000;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      // Reset values, then random write and readback, unmapped included
      foreach (addrs[i]) rd(addrs[i], {i == 6, 24'h0});
      repeat (4) foreach (addrs[i]) begin
         d = 24'($random(seed));
         d &= ~(((d & 24'h444444) >> 1) | ((d & 24'h444444) >> 2));
         wr(addrs[i], d);
         #1;
         `CHK(reg_addr_err, i == 6)
         rd(addrs[i], {i == 6, d & masks[i]});
      end
      // Power, filter and setup bits at the outputs
      d = 24'($random(seed));
      wr(16'h0822, d);
      #1;
      `CHK({aux_filter_select, main_converters_power_down}, d[9:7])
      `CHK({reference_buffer_power_down, reference_power_down}, d[6:5])
      `CHK({out_conv0_power_down, out_conv1_power_down}, d[3:2])
      `CHK({out_conv2_power_down, out_conv3_power_down}, d[1:0])
      for (int c = 0; c < 4; c++) begin
         wr(16'h0827, 24'(c));
         #1;
         `CHK({converter_setup_code, converter_init_ok}, {2'(c), c==1})
         wr(16'h0826, (c[0]) ? 24'h000004 : 24'hfffffb);
         #1;
         `CHK(osc_power_down, c[0])
      end
      // Filter flags stay low while the converter is off, then follow each filter code once it is on
      wr(16'h0824, 24'h007fff);
      wr(16'h0822, 24'h000000);
      settle(2);
      `CHK({aux_converter_on, aux_lowpass_active}, 2'h0)
      `CHK(aux_hysteresis_active, 1'b0)
      wr(16'h0824, 24'h008000);
      for (int f = 0; f < 4; f++) begin
         wr(16'h0822, 24'(f) << 8);
         settle(2);
         `CHK(aux_lowpass_active, f < 2)
         `CHK(aux_hysteresis_active, f != 2)
         `CHK(aux_hysteresis_wide, f == 1)
      end
      // Every legal code on every pin, rotated across the pins
      for (int c = 0; c < 11; c++) begin
         for (int p = 0; p < 12; p++) begin
            cd[p] = legal[(c + p) % 11];
            if (p < 6)
               lo[4*p +: 4] = cd[p];
            else
               hi[4*(p-6) +: 4] = cd[p];
         end
         wr(16'h0820, lo);
         wr(16'h0821, hi);
         settle(2);
         for (int p = 0; p < 12; p++) begin
            b = cd[p][2:0];
            v = (cd[p] < 5) || (cd[p] >= 8 && cd[p] < 13);
            pg = {pin_in_debounced[p], pin_in_raw[p], pin_drive_out[p],
               pin_open_collector[p], pin_serial_port[p], pin_aux_input[p],
               pin_invert[p], pin_pullup_en[p], pin_code_reserved[p]};
            pe = {v && b == 0, v && b == 1, v && b == 2, v && b == 3,
               v && b == 4, &cd[p], v && cd[p][3], v && b inside {0, 1, 4},
               !v && !(&cd[p])};
            `CHK(pg, pe)
         end
         `CHK(aux_channel_active, {&cd[8], &cd[3], &cd[2], &cd[9]})
      end
      // Read and write of one register in the same cycle
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_rd <= 1'b1;
      reg_addr <= 16'h0827;
      reg_wdata <= 24'h000002;
      exp_q.push_back({1'b0, 24'h000003});
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      rd(16'h0827, {1'b0, 24'h000002});
      for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge clk);
      if (exp_q.size() > 0)
         err_total++;
      complete_run();
   end
endmodule
